// ### logic/teach_diag_defs.vh
// Constants for the teach button and signal diagnostics block
`ifndef TEACH_DIAG_DEFS_VH
`define TEACH_DIAG_DEFS_VH

// Register offsets (byte addresses, one 32-bit word each)
`define REG_CTRL          8'h00
`define REG_LOCK_MIN      8'h04
`define REG_STATUS        8'h08
`define REG_MEAS_RATE     8'h0C
`define REG_REPLY_DELAY   8'h10
`define REG_EXPOSURE      8'h14
`define REG_TEACH_RESULT  8'h18

// Control register fields
`define CTRL_QUICK_BIT    0
`define CTRL_SWITCH_BIT   1

// Reset values and special lockout settings
`define CTRL_RESET        2'h0
`define LOCK_MIN_RESET    8'h05
`define LOCK_MIN_ALWAYS   8'h00
`define LOCK_MIN_NEVER    8'hFF

// Signal quality codes
`define QUAL_VALID        2'h0
`define QUAL_WEAK         2'h1
`define QUAL_CRITICAL     2'h2

// Times in their own units
`define CLK_HZ            100000000
`define HOLD_MS           2000
`define MINUTE_S          60
`define BLINK_SLOW_HZ     2
`define BLINK_FAST_HZ     8

// Cycle counts derived from the times
`define HOLD_CYC          (`CLK_HZ / 1000 * `HOLD_MS)
`define MINUTE_CYC        (64'h1 * `CLK_HZ * `MINUTE_S)
`define SLOW_HALF_CYC     (`CLK_HZ / (2 * `BLINK_SLOW_HZ))
`define FAST_HALF_CYC     (`CLK_HZ / (2 * `BLINK_FAST_HZ))

`endif

// ### logic/sync_2ff.v
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff
(
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Data
  input  wire d,
  output reg  q
);
  reg meta_q;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sync_2ff
`default_nettype wire

// ### logic/blink_gen.v
// Square wave generator with a programmable half period
`timescale 1ns/100ps
`default_nettype none
module blink_gen
#(
  parameter HALF_CYC = 25000000,
  parameter CW       = 32
)
(
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Control and wave
  input  wire run,
  output reg  wave_q
);
  reg [CW-1:0] cnt_q;

  // Restarts on every run so each blink phase opens with the LED lit
  always @(posedge ref_clk)
  begin
    if (rst || !run)
    begin
      cnt_q  <= {CW{1'b0}};
      wave_q <= 1'b0;
    end
    else if (cnt_q == 0)
    begin
      cnt_q  <= HALF_CYC[CW-1:0] - 1'b1;
      wave_q <= ~wave_q;
    end
    else
      cnt_q <= cnt_q - 1'b1;
  end
endmodule // blink_gen
`default_nettype wire

// ### logic/teach_button_and_signal_diag.v
// Teach button controller, lockout timer and signal diagnostics
//
// Summary of operation
// - Two button modes; extended is default
// - Extended: measure field, zero, factory restore; only the zero teach is implemented, field and factory hooks stay idle
// - Quick mode: only zero position teachable
// - Button locks after timeout, default five minutes
// - Timeout minutes; zero never locks, 255 always
// - Green blinks 2 Hz while teach runs
// - Successful teach returns to normal operation
// - Failed teach blinks both LEDs 8 Hz
// - Report measurement rate in measurements per second
// - Output updates once per measurement
// - Filter settings leave measurement rate alone
// - Report delay from trigger to output change
// - Filter settings leave reply delay alone
// - Publish unitless exposure reserve
// - Quality codes: 0 valid, 1 weak, 2 critical
// - LEDs blink at critical quality
// - Alarm asserted when no value is acquired
// - Output defaults to alarm, else switching
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "teach_diag_defs.vh"
module teach_button_and_signal_diag
#(
  parameter HOLD_CYC   = `HOLD_CYC,
  parameter MINUTE_CYC = `MINUTE_CYC,
  parameter SLOW_HALF  = `SLOW_HALF_CYC,
  parameter FAST_HALF  = `FAST_HALF_CYC,
  parameter RATE_CYC   = `CLK_HZ,
  parameter FAIL_CYC   = `CLK_HZ
)
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Operator pin
  input  wire        button_n,
  // Measurement core, same clock
  input  wire        meas_trigger,
  input  wire        meas_done,
  input  wire        meas_valid,
  input  wire [15:0] meas_value,
  input  wire [7:0]  exposure_in,
  input  wire [1:0]  quality_in,
  input  wire        switch_state,
  // Teach engine, same clock
  output reg         zero_teach_q,
  output reg         field_teach_q,
  output reg         factory_restore_q,
  input  wire        teach_done,
  input  wire        teach_ok,
  // Outputs
  output reg  [15:0] out_value_q,
  output reg         green_led_q,
  output reg         yellow_led_q,
  output reg         out_pin_q
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_HOLD  = 2'h1;
  localparam ST_TEACH = 2'h2;
  localparam ST_FAIL  = 2'h3;

  wire        btn;
  wire        slow_wave;
  wire        fast_wave;
  reg  [1:0]  state_q;
  reg  [31:0] hold_cnt_q;
  reg  [31:0] fail_cnt_q;
  reg  [1:0]  ctrl_q;
  reg  [7:0]  lock_min_q;
  // A minute at the full clock rate does not fit in 32 bits
  reg  [39:0] min_cnt_q;
  reg  [7:0]  min_elapsed_q;
  reg         locked_q;

  // Diagnostic capture
  reg  [31:0] sec_cnt_q;
  reg  [31:0] rate_acc_q;
  reg  [31:0] measure_rate_value_q;
  reg  [31:0] delay_cnt_q;
  reg  [31:0] reply_delay_value_q;
  reg  [7:0]  exposure_q;
  reg  [1:0]  quality_q;
  reg         last_ok_q;
  reg         crit_blink;
  reg  [31:0] read_mux;

  wire quick_mode = ctrl_q[`CTRL_QUICK_BIT];
  wire button_on  = !locked_q && lock_min_q != `LOCK_MIN_NEVER;
  // Blink generators restart whenever their phase begins
  wire slow_run   = (state_q == ST_TEACH);
  wire fast_run   = (state_q == ST_FAIL) || crit_blink;

  sync_2ff u_btn_sync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (~button_n),
    .q       (btn)
  );

  blink_gen #(.HALF_CYC(SLOW_HALF)) u_slow
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (slow_run),
    .wave_q  (slow_wave)
  );

  blink_gen #(.HALF_CYC(FAST_HALF)) u_fast
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (fast_run),
    .wave_q  (fast_wave)
  );

  // Register writes
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_q     <= `CTRL_RESET;
      lock_min_q <= `LOCK_MIN_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `REG_CTRL)
        ctrl_q <= reg_wdata[1:0];
      if (reg_addr == `REG_LOCK_MIN)
        lock_min_q <= reg_wdata[7:0];
    end
  end

  // Read decode kept apart so the data flop only picks it or zero
  always @*
  begin
    read_mux = 32'h0;
    case (reg_addr)
      `REG_CTRL:         read_mux = {30'h0, ctrl_q};
      `REG_LOCK_MIN:     read_mux = {24'h0, lock_min_q};
      `REG_STATUS:       read_mux = {27'h0, locked_q, state_q, quality_q};
      `REG_MEAS_RATE:    read_mux = measure_rate_value_q;
      `REG_REPLY_DELAY:  read_mux = reply_delay_value_q;
      `REG_EXPOSURE:     read_mux = {24'h0, exposure_q};
      `REG_TEACH_RESULT: read_mux = {31'h0, last_ok_q};
      default:           read_mux = 32'h0;
    endcase
  end

  // Register reads: data one cycle after the strobe, zero otherwise
  always @(posedge ref_clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= read_mux;
  end

  // Button sequence
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q           <= ST_IDLE;
      hold_cnt_q        <= 32'h0;
      fail_cnt_q        <= 32'h0;
      zero_teach_q      <= 1'b0;
      field_teach_q     <= 1'b0;
      factory_restore_q <= 1'b0;
      last_ok_q         <= 1'b0;
    end
    else
    begin
      zero_teach_q      <= 1'b0;
      field_teach_q     <= 1'b0;
      factory_restore_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          hold_cnt_q <= 32'h0;
          if (btn && button_on)
            state_q <= ST_HOLD;
        end
        ST_HOLD:
        begin
          if (!btn)
            state_q <= ST_IDLE;
          else if (hold_cnt_q == HOLD_CYC - 1)
          begin
            state_q      <= ST_TEACH;
            zero_teach_q <= 1'b1;
          end
          else
            hold_cnt_q <= hold_cnt_q + 32'h1;
          // Extended mode keeps its field and factory hooks idle: no button
          // sequence is defined for them, so only the zero teach is reachable
          if (!quick_mode && btn && hold_cnt_q == HOLD_CYC - 1)
          begin
            field_teach_q     <= 1'b0;
            factory_restore_q <= 1'b0;
          end
        end
        ST_TEACH:
        begin
          if (teach_done)
          begin
            last_ok_q  <= teach_ok;
            fail_cnt_q <= 32'h0;
            state_q    <= teach_ok ? ST_IDLE : ST_FAIL;
          end
        end
        default:
        begin
          if (fail_cnt_q == FAIL_CYC - 1)
            state_q <= ST_IDLE;
          else
            fail_cnt_q <= fail_cnt_q + 32'h1;
        end
      endcase
    end
  end

  // Lockout: minutes counted since the last teach or a new timeout value
  // A value of 255 is refused in button_on whatever this count says
  always @(posedge ref_clk)
  begin
    if (rst || zero_teach_q || reg_wr && reg_addr == `REG_LOCK_MIN)
    begin
      min_cnt_q     <= 40'h0;
      min_elapsed_q <= 8'h0;
      locked_q      <= 1'b0;
    end
    else if (lock_min_q == `LOCK_MIN_ALWAYS)
      locked_q <= 1'b0;
    else if (!locked_q)
    begin
      if (min_cnt_q == MINUTE_CYC - 1)
      begin
        min_cnt_q     <= 40'h0;
        min_elapsed_q <= min_elapsed_q + 8'h1;
        if (min_elapsed_q + 8'h1 >= lock_min_q)
          locked_q <= 1'b1;
      end
      else
        min_cnt_q <= min_cnt_q + 40'h1;
    end
  end

  // Diagnostics, independent of any filter setting
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sec_cnt_q            <= 32'h0;
      rate_acc_q           <= 32'h0;
      measure_rate_value_q <= 32'h0;
      delay_cnt_q          <= 32'h0;
      reply_delay_value_q  <= 32'h0;
      exposure_q           <= 8'h0;
      quality_q            <= `QUAL_VALID;
      out_value_q          <= 16'h0;
    end
    else
    begin
      // One count of results per window of RATE_CYC cycles
      if (sec_cnt_q == RATE_CYC - 1)
      begin
        sec_cnt_q            <= 32'h0;
        measure_rate_value_q <= rate_acc_q + {31'h0, meas_done};
        rate_acc_q           <= 32'h0;
      end
      else
      begin
        sec_cnt_q  <= sec_cnt_q + 32'h1;
        rate_acc_q <= rate_acc_q + {31'h0, meas_done};
      end
      // The delay runs only from a trigger to its result and never wraps
      if (meas_trigger)
        delay_cnt_q <= 32'h1;
      else if (meas_done)
        delay_cnt_q <= 32'h0;
      else if (delay_cnt_q != 32'h0 && delay_cnt_q != 32'hFFFFFFFF)
        delay_cnt_q <= delay_cnt_q + 32'h1;
      // A result without a trigger keeps the last reported delay
      if (meas_done && delay_cnt_q != 32'h0)
        reply_delay_value_q <= delay_cnt_q;
      if (meas_done)
      begin
        out_value_q         <= meas_value;
        exposure_q          <= exposure_in;
        quality_q           <= (quality_in > `QUAL_CRITICAL) ? `QUAL_CRITICAL : quality_in;
      end
    end
  end

  always @*
    crit_blink = (quality_q == `QUAL_CRITICAL);

  // LEDs and switchable output
  // Teach blink first, then failure or critical blink, else plain status
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      green_led_q  <= 1'b0;
      yellow_led_q <= 1'b0;
      out_pin_q    <= 1'b0;
    end
    else
    begin
      if (state_q == ST_TEACH)
      begin
        green_led_q  <= slow_wave;
        yellow_led_q <= 1'b0;
      end
      else if (state_q == ST_FAIL || crit_blink)
      begin
        green_led_q  <= fast_wave;
        yellow_led_q <= fast_wave;
      end
      else
      begin
        green_led_q  <= meas_valid;
        yellow_led_q <= !meas_valid;
      end
      out_pin_q <= ctrl_q[`CTRL_SWITCH_BIT] ? switch_state : !meas_valid;
    end
  end
endmodule // teach_button_and_signal_diag
`default_nettype wire

// ### verif/teach_engine_model.sv
// Teach engine stand-in that answers a zero-position teach request
`timescale 1ns/100ps
`default_nettype none
module teach_engine_model
#(
  parameter DELAY = 22
)
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Request and answer
  input  wire logic start,
  input  wire logic fail_mode,
  output var  logic done,
  output var  logic ok
);
  int cnt;
  always @(posedge ref_clk)
  begin
    done <= 1'b0;
    // Outside the answer cycle the level means nothing, so keep it moving
    ok <= ~ok;
    if (rst)
    begin
      cnt <= 0;
      ok  <= 1'b0;
    end
    else if (start)
      cnt <= DELAY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (!rst && cnt == 1)
    begin
      done <= 1'b1;
      ok   <= !fail_mode;
    end
  end
endmodule // teach_engine_model
`default_nettype wire

// ### verif/teach_diag_chk.sv
// Assertion checker for the teach button and diagnostics block
`timescale 1ns/100ps
`default_nettype none
module teach_diag_chk
#(
  parameter HOLD_CYC = 20
)
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Watched ports
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        button_n,
  input wire logic        meas_done,
  input wire logic        meas_valid,
  input wire logic [15:0] meas_value,
  input wire logic        switch_state,
  input wire logic        zero_teach_q,
  input wire logic        field_teach_q,
  input wire logic        factory_restore_q,
  input wire logic        teach_done,
  input wire logic        teach_ok,
  input wire logic [15:0] out_value_q,
  input wire logic        green_led_q,
  input wire logic        yellow_led_q,
  input wire logic        out_pin_q
);
  logic       sw_q;
  logic [7:0] hold_q;
  logic       teach_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sw_q    <= 1'b0;
      hold_q  <= 8'h00;
      teach_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h00)
        sw_q <= reg_wdata[1];
      hold_q  <= button_n ? 8'h00 : (hold_q == 8'hFF ? hold_q : hold_q + 8'h01);
      teach_q <= zero_teach_q | (teach_q & ~teach_done);
    end
  end
  a_hooks_idle: assert property (!field_teach_q && !factory_restore_q)
    else $error("extended hook driven");
  a_hold_before_teach: assert property (zero_teach_q |-> hold_q >= HOLD_CYC)
    else $error("teach without full hold");
  a_out_on_done: assert property (meas_done |=> out_value_q == $past(meas_value))
    else $error("output missed measurement");
  a_out_holds: assert property (!meas_done |=> $stable(out_value_q))
    else $error("output changed between measurements");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_pin_source: assert property ($stable(meas_valid) && $stable(switch_state) && $stable(sw_q) |=>
    out_pin_q == ($past(sw_q) ? $past(switch_state) : !$past(meas_valid)))
    else $error("output pin wrong source");
  a_teach_blink: assert property (teach_q && $rose(green_led_q) |=> green_led_q[*3] ##1 !green_led_q)
    else $error("teach blink period wrong");
  a_fail_phase: assert property (teach_done && !teach_ok |=> ##2 (green_led_q == yellow_led_q)[*8])
    else $error("fail blink out of phase");
  a_fail_rate: assert property (teach_done && !teach_ok |-> ##[2:6] $rose(green_led_q) ##1 green_led_q ##1 !green_led_q)
    else $error("fail blink period wrong");
  a_ok_return: assert property (teach_done && teach_ok |-> ##[1:4] (green_led_q == meas_valid && yellow_led_q != meas_valid))
    else $error("no return to operation");
endmodule // teach_diag_chk
bind teach_button_and_signal_diag teach_diag_chk #(.HOLD_CYC(HOLD_CYC)) chk_i (.*);
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the teach button and diagnostics block
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; } row_t;
  logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, button_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00, exposure_in = 8'h3C;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic        meas_trigger = 1'b0, meas_done = 1'b0, meas_valid = 1'b1, switch_state = 1'b0;
  logic [15:0] meas_value = 16'h0, out_value_q;
  logic [1:0]  quality_in = 2'h0;
  logic        zero_teach_q, field_teach_q, factory_restore_q, teach_done, teach_ok, fail_mode = 1'b0;
  logic        green_led_q, yellow_led_q, out_pin_q, g_prev;
  int          n_errors = 0, total_checks = 0, n_teach = 0, n_tog = 0;
  row_t        rows [7] = '{'{0, 8'h00, 0}, '{0, 8'h04, 5}, '{0, 8'h1C, 0}, '{1, 8'h04, 0},
                            '{0, 8'h04, 0}, '{1, 8'h00, 1}, '{0, 8'h00, 1}};
  teach_button_and_signal_diag #(.HOLD_CYC(20), .MINUTE_CYC(50), .SLOW_HALF(4), .FAST_HALF(2),
    .RATE_CYC(100), .FAIL_CYC(40)) teach_button_and_signal_diag_i (.*);
  teach_engine_model teach_engine_model_i (.ref_clk(ref_clk), .rst(rst), .start(zero_teach_q),
    .fail_mode(fail_mode), .done(teach_done), .ok(teach_ok));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n_teach += (zero_teach_q === 1'b1);
    n_tog   += (green_led_q !== g_prev);
    g_prev = green_led_q;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task meas(input logic [15:0] v, input logic [1:0] q, input logic ok);
    @(posedge ref_clk) meas_trigger <= 1'b1;
    @(posedge ref_clk) meas_trigger <= 1'b0;
    repeat (5) @(posedge ref_clk);
    {meas_done, meas_value, quality_in, meas_valid, exposure_in} <= {1'b1, v, q, ok, v[7:0]};
    @(posedge ref_clk) meas_done <= 1'b0;
    #1;
  endtask
  task press(input int n);
    @(posedge ref_clk) button_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    button_n <= 1'b1;
    repeat (30) @(posedge ref_clk);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i])
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rc(rows[i].a, rows[i].d);
    for (int q = 0; q < 3; q++)
    begin
      meas(16'h1230 + q, q[1:0], 1'b1);
      chk({16'h0, out_value_q}, 32'h1230 + q);
      rc(8'h10, 32'h6);
      rd(8'h08);
      chk(rv[1:0], q);
    end
    rc(8'h14, 32'h32);
    n_tog = 0;
    repeat (20) @(posedge ref_clk);
    chk(n_tog > 3, 1);
    meas(16'h0, 2'h0, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk(out_pin_q, 1);
    wr(8'h00, 32'h3);
    switch_state <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(out_pin_q, 1);
    switch_state <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(out_pin_q, 0);
    wr(8'h00, 32'h1);
    repeat (30) meas(16'h0, 2'h0, 1'b1);
    rd(8'h0C);
    chk(rv == 32'hC || rv == 32'hD, 1);
    press(10);
    chk(n_teach, 0);
    press(25);
    chk(n_teach, 1);
    rc(8'h18, 32'h1);
    fail_mode <= 1'b1;
    press(25);
    repeat (40) @(posedge ref_clk);
    chk(n_teach, 2);
    rc(8'h18, 32'h0);
    fail_mode <= 1'b0;
    wr(8'h04, 32'h1);
    repeat (60) @(posedge ref_clk);
    rd(8'h08);
    chk(rv[4], 1);
    press(25);
    chk(n_teach, 2);
    wr(8'h04, 32'hFF);
    press(25);
    chk(n_teach, 2);
    wr(8'h04, 32'h0);
    press(25);
    chk(n_teach, 3);
    final_report();
  end
endmodule // tb
`default_nettype wire
